/* File: sdp_fifo.sv */
/*
  Synchronous FIFO with valid/ready on both sides, width and depth set by
  parameters. Assumes one clock and a depth that is a power of two.
*/
`timescale 1ns/1ns
module sdp_fifo #(
  parameter int unsigned WIDTH = 10,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             mclk_i,
  input  wire logic             rst_b_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);

  localparam int unsigned AW = $clog2(DEPTH);

  initial begin
    if (WIDTH < 1 || DEPTH < 2 || (1 << AW) != DEPTH) begin
      $error("sdp_fifo: WIDTH must be >= 1 and DEPTH a power of two >= 2");
    end
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr_reg;
  logic [AW:0]      wr_ptr_next;
  logic [AW:0]      rd_ptr_reg;
  logic [AW:0]      rd_ptr_next;
  logic             full;
  logic             empty;
  logic             push;
  logic             pop;

  always_comb begin
    full        = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
                  (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
    empty       = (wr_ptr_reg == rd_ptr_reg);
    push        = in_valid_i && !full;
    pop         = out_ready_i && !empty;
    wr_ptr_next = push ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
    rd_ptr_next = pop ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
    in_ready_o  = !full;
    out_valid_o = !empty;
    out_data_o  = mem[rd_ptr_reg[AW-1:0]];
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
    end
  end

  // storage carries no reset; only words behind the pointers are read
  always_ff @(posedge mclk_i) begin
    if (push) begin
      mem[wr_ptr_reg[AW-1:0]] <= in_data_i;
    end
  end

endmodule

/* File: sdp_pkg.sv */
/*
  Shared constants and types of the serdes parallel port: word and group
  widths, bit-clock phase points of the receive byte clocks, FIFO depth.
  Assumes the block clock runs at one serial bit per cycle.
*/
package sdp_pkg;

  localparam int unsigned SDP_WORD_BITS  = 10;
  localparam int unsigned SDP_GROUP_BITS = 5;
  localparam int unsigned SDP_FIFO_DEPTH = 16;

  // outside clock limits, kept for reference by the far side
  localparam int unsigned SDP_REFERENCE_CLOCK_IN_MIN_MHZ = 100;
  localparam int unsigned SDP_REFERENCE_CLOCK_IN_MAX_MHZ = 160;
  localparam int unsigned SDP_MCLK_PERIOD_NS = 8;

  // serializer and deserializer bit counters
  localparam logic [3:0] SDP_TX_LAST_BIT = 4'h9;
  localparam logic [3:0] SDP_RX_LAST_BIT = 4'h9;

  // byte clock phase points, in serial bit times
  localparam logic [4:0] SDP_FULL_PERIOD = 5'h0a;
  localparam logic [4:0] SDP_FULL_HIGH   = 5'h05;
  localparam logic [4:0] SDP_FULL_LOAD   = 5'h07;
  localparam logic [4:0] SDP_DDR_HI_LOAD = 5'h02;
  localparam logic [4:0] SDP_HALF_PERIOD = 5'h14;
  localparam logic [4:0] SDP_HALF_HIGH   = 5'h0a;
  localparam logic [4:0] SDP_HALF_LOAD_B = 5'h05;
  localparam logic [4:0] SDP_HALF_LOAD_A = 5'h0f;

  typedef enum logic [1:0] {
    SDP_MODE_HALF,
    SDP_MODE_FULL,
    SDP_MODE_DDR
  } sdp_mode_t;

endpackage

/* File: sdp_port.sv */
/*
  Parallel side of a gigabit serializer/deserializer: transmit word capture
  on the reference clock, bit-serial transmit, receive deserializer, receive
  FIFO and the recovered byte clocks in half-rate, full-rate and DDR modes.
  Assumes mclk_i is the serial bit clock (one bit per cycle); all pins except rst_b_i and realign_i are
  asynchronous to it and pass two flip-flops before use. Word boundary slip
  requests come from a comma detector outside this block.
*/
`timescale 1ns/1ns
module sdp_port
  import sdp_pkg::*;
#(
  parameter int unsigned FIFO_DEPTH = SDP_FIFO_DEPTH
) (
  input  wire logic       mclk_i,
  input  wire logic       rst_b_i,
  input  wire logic       reference_clock_in_i,
  input  wire logic [9:0] tx_parallel_word_i,
  input  wire logic       interface_width_select_i,
  input  wire logic       rx_clock_rate_select_i,
  input  wire logic       loopback_enable_i,
  input  wire logic       serial_in_pair_i,
  input  wire logic       realign_i,
  output logic            serial_out_pair_o,
  output logic            serial_out_pair_oe_o,
  output logic      [9:0] rx_parallel_word_o,
  output logic            rx_byte_clock_a_o,
  output logic            rx_byte_clock_b_o,
  output logic            rx_overflow_o
);

  initial begin
    if (FIFO_DEPTH < 2) begin
      $error("sdp_port: FIFO_DEPTH must be at least 2");
    end
  end

  function automatic sdp_mode_t sdp_mode_f(input logic width_sel, input logic rate_sel);
    if (width_sel) begin
      return SDP_MODE_DDR;
    end else if (rate_sel) begin
      return SDP_MODE_FULL;
    end
    return SDP_MODE_HALF;
  endfunction

  // pin synchronisers; the first stage feeds only the second
  logic [9:0] txw_s1_reg;
  logic [9:0] txw_s2_reg;
  logic [4:0] pin_s1_reg;
  logic [4:0] pin_s2_reg;
  logic       ref_s3_reg;
  logic       ref_s2;
  logic       width_s2;
  logic       rate_s2;
  logic       loop_s2;
  logic       ser_in_s2;

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      txw_s1_reg <= '0;
      txw_s2_reg <= '0;
      pin_s1_reg <= '0;
      pin_s2_reg <= '0;
      ref_s3_reg <= 1'b0;
    end else begin
      txw_s1_reg <= tx_parallel_word_i;
      txw_s2_reg <= txw_s1_reg;
      pin_s1_reg <= {reference_clock_in_i, interface_width_select_i,
                     rx_clock_rate_select_i, loopback_enable_i, serial_in_pair_i};
      pin_s2_reg <= pin_s1_reg;
      ref_s3_reg <= ref_s2;
    end
  end

  assign ref_s2    = pin_s2_reg[4];
  assign width_s2  = pin_s2_reg[3];
  assign rate_s2   = pin_s2_reg[2];
  assign loop_s2   = pin_s2_reg[1];
  assign ser_in_s2 = pin_s2_reg[0];

  sdp_mode_t mode;
  logic      ref_rise;
  logic      ref_fall;

  assign mode     = sdp_mode_f(width_s2, rate_s2);
  assign ref_rise = ref_s2 && !ref_s3_reg;
  assign ref_fall = !ref_s2 && ref_s3_reg;

  // transmit capture and serializer
  logic [9:0] tx_hold_reg;
  logic [9:0] tx_hold_next;
  logic       tx_pend_reg;
  logic       tx_pend_next;
  logic [9:0] tx_shift_reg;
  logic [9:0] tx_shift_next;
  logic [3:0] tx_left_reg;
  logic [3:0] tx_left_next;
  logic       tx_bit_reg;
  logic       tx_bit_next;
  logic       tx_oe_reg;
  logic       tx_oe_next;

  always_comb begin
    tx_hold_next  = tx_hold_reg;
    tx_pend_next  = tx_pend_reg;
    tx_shift_next = tx_shift_reg;
    tx_left_next  = tx_left_reg;
    tx_bit_next   = 1'b0;
    // an idle line sends zeros until the first captured word
    if (tx_left_reg != 4'h0) begin
      tx_bit_next   = tx_shift_reg[0];
      tx_shift_next = {1'b0, tx_shift_reg[9:1]};
      tx_left_next  = tx_left_reg - 4'h1;
    end else if (tx_pend_reg) begin
      tx_bit_next   = tx_hold_reg[0];
      tx_shift_next = {1'b0, tx_hold_reg[9:1]};
      tx_left_next  = SDP_TX_LAST_BIT;
      tx_pend_next  = 1'b0;
    end
    // a capture in the same cycle as the load wins over the clear
    if (mode == SDP_MODE_DDR) begin
      if (ref_rise) begin
        tx_hold_next[SDP_GROUP_BITS-1:0] = txw_s2_reg[SDP_GROUP_BITS-1:0];
      end
      if (ref_fall) begin
        tx_hold_next[SDP_WORD_BITS-1:SDP_GROUP_BITS] = txw_s2_reg[SDP_GROUP_BITS-1:0];
        tx_pend_next = 1'b1;
      end
    end else if (ref_rise) begin
      tx_hold_next = txw_s2_reg;
      tx_pend_next = 1'b1;
    end
    tx_oe_next = !loop_s2;
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tx_hold_reg  <= '0;
      tx_pend_reg  <= 1'b0;
      tx_shift_reg <= '0;
      tx_left_reg  <= '0;
      tx_bit_reg   <= 1'b0;
      tx_oe_reg    <= 1'b0;
    end else begin
      tx_hold_reg  <= tx_hold_next;
      tx_pend_reg  <= tx_pend_next;
      tx_shift_reg <= tx_shift_next;
      tx_left_reg  <= tx_left_next;
      tx_bit_reg   <= tx_bit_next;
      tx_oe_reg    <= tx_oe_next;
    end
  end

  // receive deserializer
  logic       rx_bit;
  logic [9:0] rx_sr_reg;
  logic [9:0] rx_sr_next;
  logic [3:0] rx_cnt_reg;
  logic [3:0] rx_cnt_next;
  logic       push_reg;
  logic       push_next;
  logic [9:0] push_data_reg;
  logic [9:0] push_data_next;
  logic       ovf_reg;
  logic       ovf_next;
  logic       fifo_in_ready;
  logic       fifo_out_valid;
  logic [9:0] fifo_out_data;
  logic       pop;

  assign rx_bit = loop_s2 ? tx_bit_reg : ser_in_s2;

  always_comb begin
    // earliest bit ends in bit zero
    rx_sr_next     = {rx_bit, rx_sr_reg[9:1]};
    rx_cnt_next    = rx_cnt_reg;
    push_next      = 1'b0;
    push_data_next = push_data_reg;
    // a slip request lengthens this word by one bit
    if (!realign_i) begin
      if (rx_cnt_reg == SDP_RX_LAST_BIT) begin
        rx_cnt_next    = 4'h0;
        push_next      = 1'b1;
        push_data_next = rx_sr_next;
      end else begin
        rx_cnt_next = rx_cnt_reg + 4'h1;
      end
    end
    // the serial stream cannot wait, so a full FIFO drops the word
    ovf_next = ovf_reg || (push_reg && !fifo_in_ready);
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rx_sr_reg     <= '0;
      rx_cnt_reg    <= '0;
      push_reg      <= 1'b0;
      push_data_reg <= '0;
      ovf_reg       <= 1'b0;
    end else begin
      rx_sr_reg     <= rx_sr_next;
      rx_cnt_reg    <= rx_cnt_next;
      push_reg      <= push_next;
      push_data_reg <= push_data_next;
      ovf_reg       <= ovf_next;
    end
  end

  sdp_fifo #(
    .WIDTH (SDP_WORD_BITS),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .mclk_i      (mclk_i),
    .rst_b_i     (rst_b_i),
    .in_valid_i  (push_reg),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (push_data_reg),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (pop),
    .out_data_o  (fifo_out_data)
  );

  // byte clock generator and receive word output
  logic [4:0] ph_reg;
  logic [4:0] ph_next;
  logic [4:0] ph_limit;
  logic [9:0] word_reg;
  logic [9:0] word_next;
  logic [9:0] rd_reg;
  logic [9:0] rd_next;
  logic       clk_a_reg;
  logic       clk_a_next;
  logic       clk_b_reg;
  logic       clk_b_next;
  logic       is_load;
  logic       stall;

  always_comb begin
    ph_limit = (mode == SDP_MODE_HALF) ? SDP_HALF_PERIOD : SDP_FULL_PERIOD;
    // load at 5 serves b (even words), at 15 serves a (odd)
    if (mode == SDP_MODE_HALF) begin
      is_load = (ph_reg == SDP_HALF_LOAD_B) || (ph_reg == SDP_HALF_LOAD_A);
    end else begin
      is_load = (ph_reg == SDP_FULL_LOAD);
    end
    // empty FIFO freezes the clocks, so phases only stretch
    stall     = is_load && !fifo_out_valid;
    pop       = is_load && fifo_out_valid;
    ph_next   = ph_reg;
    word_next = word_reg;
    rd_next   = rd_reg;
    if (!stall) begin
      ph_next = (ph_reg >= ph_limit - 5'h01) ? 5'h00 : ph_reg + 5'h01;
    end
    if (pop) begin
      word_next = fifo_out_data;
      if (mode == SDP_MODE_DDR) begin
        // bit-zero group ahead of the rise
        rd_next = {{SDP_WORD_BITS-SDP_GROUP_BITS{1'b0}}, fifo_out_data[SDP_GROUP_BITS-1:0]};
      end else begin
        rd_next = fifo_out_data;
      end
    end else if (mode == SDP_MODE_DDR && ph_reg == SDP_DDR_HI_LOAD) begin
      // second group ahead of the fall
      rd_next = {{SDP_WORD_BITS-SDP_GROUP_BITS{1'b0}},
                 word_reg[SDP_WORD_BITS-1:SDP_GROUP_BITS]};
    end
    if (mode == SDP_MODE_HALF) begin
      // two halves of a 20-bit period
      clk_a_next = (ph_next < SDP_HALF_HIGH);
      clk_b_next = (ph_next >= SDP_HALF_HIGH);
    end else begin
      clk_a_next = (ph_next < SDP_FULL_HIGH);
      clk_b_next = 1'b0;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ph_reg    <= '0;
      word_reg  <= '0;
      rd_reg    <= '0;
      clk_a_reg <= 1'b0;
      clk_b_reg <= 1'b0;
    end else begin
      ph_reg    <= ph_next;
      word_reg  <= word_next;
      rd_reg    <= rd_next;
      clk_a_reg <= clk_a_next;
      clk_b_reg <= clk_b_next;
    end
  end

  assign serial_out_pair_o    = tx_bit_reg;
  assign serial_out_pair_oe_o = tx_oe_reg;
  assign rx_parallel_word_o   = rd_reg;
  assign rx_byte_clock_a_o    = clk_a_reg;
  assign rx_byte_clock_b_o    = clk_b_reg;
  assign rx_overflow_o        = ovf_reg;

endmodule

/* File: sdp_proto_model.sv */
/*
  Protocol device model: presents transmit words with a reference clock.
  Assumes the caller keeps word starts on a ten-cycle grid.
*/
`timescale 1ns/1ns
module sdp_proto_model (
  input  wire logic       mclk_i,
  input  wire logic       ddr_i,
  output logic            reference_clock_in_o,
  output logic      [9:0] word_o
);
  initial begin
    reference_clock_in_o = 1'b0;
    word_o   = 10'h000;
  end
  // word rate kept at a twentieth of the bit rate
  // low group at rise, high group at fall
  task automatic send(input logic [9:0] w);
    @(negedge mclk_i);
    word_o = ddr_i ? {~w[9:5], w[4:0]} : w;
    repeat (2) @(negedge mclk_i);
    reference_clock_in_o = 1'b1;
    repeat (5) @(negedge mclk_i);
    word_o = ddr_i ? {~w[4:0], w[9:5]} : ~w;
    // fall ten cycles after rise keeps ddr words on the same grid
    repeat (5) @(negedge mclk_i);
    reference_clock_in_o = 1'b0;
    repeat (5) @(negedge mclk_i);
    word_o = ~word_o;
    // twenty cycles per call keeps back-to-back words on the ten-bit grid
    repeat (2) @(negedge mclk_i);
  endtask
endmodule

/* File: sdp_sva.sv */
/*
  Checker for sdp_port: output enable, byte clock shapes and receive word
  timing. Assumes inputs from a bench that drives pins off the clock edge.
*/
`timescale 1ns/1ns
module sdp_sva (
  input wire logic       mclk_i,
  input wire logic       rst_b_i,
  input wire logic       interface_width_select_i,
  input wire logic       rx_clock_rate_select_i,
  input wire logic       loopback_enable_i,
  input wire logic       serial_out_pair_oe_o,
  input wire logic [9:0] rx_parallel_word_o,
  input wire logic       rx_byte_clock_a_o,
  input wire logic       rx_byte_clock_b_o
);
  logic [1:0] mode_reg;
  logic [4:0] calm_reg;
  logic [4:0] calm_next;
  logic       half;
  logic       full;
  logic       ddr;
  // a mode change may give one short phase, so checks wait for calm
  always_comb begin
    calm_next = calm_reg + {4'h0, calm_reg != 5'h1f};
    if (mode_reg != {interface_width_select_i, rx_clock_rate_select_i}) calm_next = 5'h00;
  end
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mode_reg <= 2'h0;
      calm_reg <= 5'h00;
    end else begin
      mode_reg <= {interface_width_select_i, rx_clock_rate_select_i};
      calm_reg <= calm_next;
    end
  end
  assign half = calm_reg == 5'h1f && !interface_width_select_i && !rx_clock_rate_select_i;
  assign full = calm_reg == 5'h1f && !interface_width_select_i && rx_clock_rate_select_i;
  assign ddr  = calm_reg == 5'h1f && interface_width_select_i;
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_b_i);
  sequence s_a_hi;
    rx_byte_clock_a_o [*5];
  endsequence
  sequence s_a_lo;
    !rx_byte_clock_a_o [*5];
  endsequence
  sequence s_a_long;
    rx_byte_clock_a_o [*8] ##1 rx_byte_clock_a_o [*2];
  endsequence
  sequence s_b_long;
    rx_byte_clock_b_o [*8] ##1 rx_byte_clock_b_o [*2];
  endsequence
  a_oe_off_loop: assert property (loopback_enable_i [*4] |-> !serial_out_pair_oe_o)
    else $error("output enabled during loopback");
  a_oe_on_run: assert property (!loopback_enable_i [*4] |-> serial_out_pair_oe_o)
    else $error("output not driven outside loopback");
  a_b_held_low: assert property ((full || ddr) |-> !rx_byte_clock_b_o)
    else $error("byte clock b runs outside half rate");
  a_ddr_upper_zero: assert property (ddr |-> rx_parallel_word_o[9:5] == 5'h00)
    else $error("upper receive bits not low in ddr");
  a_full_clk_shape: assert property (full && $rose(rx_byte_clock_a_o) |-> s_a_hi ##1 s_a_lo)
    else $error("byte clock a period wrong in full rate");
  a_full_word_hold: assert property (full && $rose(rx_byte_clock_a_o)
    |-> $stable(rx_parallel_word_o) [*5])
    else $error("full rate word moves near clock a rise");
  a_half_antiphase: assert property (half && $fell(rx_byte_clock_a_o)
    |-> $rose(rx_byte_clock_b_o))
    else $error("half rate clocks not in antiphase");
  a_half_a_long: assert property (half && $rose(rx_byte_clock_a_o) |-> s_a_long)
    else $error("clock a high phase shortened");
  a_half_b_long: assert property (half && $rose(rx_byte_clock_b_o) |-> s_b_long)
    else $error("clock b high phase shortened");
  a_half_word_hold: assert property (half && $rose(rx_byte_clock_b_o)
    |-> $stable(rx_parallel_word_o) [*5])
    else $error("half rate word moves near clock b rise");
  a_ddr_group_hold: assert property (ddr && $changed(rx_byte_clock_a_o)
    |-> $stable(rx_parallel_word_o) [*2])
    else $error("ddr group moves at clock a edge");
endmodule
bind sdp_port sdp_sva u_sva (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
  .interface_width_select_i(interface_width_select_i),
  .rx_clock_rate_select_i(rx_clock_rate_select_i), .loopback_enable_i(loopback_enable_i),
  .serial_out_pair_oe_o(serial_out_pair_oe_o), .rx_parallel_word_o(rx_parallel_word_o),
  .rx_byte_clock_a_o(rx_byte_clock_a_o), .rx_byte_clock_b_o(rx_byte_clock_b_o));

/* File: testbench.sv */
/*
  Self-checking bench for sdp_port: transmit order, loopback receive in
  full, ddr and half rate. Assumes sdp_proto_model and sdp_sva.
*/
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin n_fail++; \
  $display("ERROR %s expected %h seen %h", nm, exp, got); end end
module testbench;
  import sdp_pkg::*;
  localparam logic [9:0] W = 10'h237;
  logic       mclk_i  = 1'b0;
  logic       rst_b_i = 1'b0;
  logic       width   = 1'b0;
  logic       rate    = 1'b1;
  logic       loop    = 1'b0;
  logic       realign = 1'b0;
  logic       ser_in  = 1'b0;
  logic       tog     = 1'b0;
  logic       reference_clock_in, ser_out, oe, clk_a, clk_b, ovf;
  logic [9:0] txw, rxw;
  int         n_fail = 0, tests_run = 0, cyc = 0, g0 = 0;
  always #4 mclk_i = ~mclk_i;
  // released line toggles so a stale level is never read as data
  always @(negedge mclk_i) begin
    tog <= ~tog;
    ser_in <= oe ? ser_out : tog;
  end
  sdp_proto_model proto (.mclk_i(mclk_i), .ddr_i(width), .reference_clock_in_o(reference_clock_in), .word_o(txw));
  sdp_port #(.FIFO_DEPTH(SDP_FIFO_DEPTH)) DUT (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
    .reference_clock_in_i(reference_clock_in), .tx_parallel_word_i(txw), .interface_width_select_i(width),
    .rx_clock_rate_select_i(rate), .loopback_enable_i(loop), .serial_in_pair_i(ser_in),
    .realign_i(realign), .serial_out_pair_o(ser_out), .serial_out_pair_oe_o(oe),
    .rx_parallel_word_o(rxw), .rx_byte_clock_a_o(clk_a), .rx_byte_clock_b_o(clk_b),
    .rx_overflow_o(ovf));
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 6000) begin
      n_fail++;
      final_report();
    end
  end
  task automatic final_report();
    if (n_fail == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic cycles(input int n);
    repeat (n) @(negedge mclk_i);
  endtask
  // tx start phase must match the receive boundary found during alignment
  task automatic on_grid();
    while ((cyc - g0) % 10 != 0) @(negedge mclk_i);
  endtask
  task automatic t_tx(input logic [9:0] w);
    logic [9:0] got;
    int         k;
    got = 10'h000;
    k = 0;
    fork
      proto.send(w);
      begin
        while (ser_out !== 1'b1 && k < 40) begin
          @(negedge mclk_i);
          k++;
        end
        for (int i = 0; i < 10; i++) begin
          got[i] = ser_out;
          @(negedge mclk_i);
        end
      end
    join
    `CHK("tx serial word", w, got)
    `CHK("tx driven", 1'b1, oe)
  endtask
  task automatic t_align();
    logic found, pa;
    found = 1'b0;
    pa = 1'b1;
    loop = 1'b1;
    cycles(8);
    `CHK("tx released", 1'b0, oe)
    for (int k = 0; k < 12 && !found; k++) begin
      g0 = cyc;
      fork
        proto.send(W);
        repeat (49) begin
          @(negedge mclk_i);
          if (clk_a && !pa && rxw === W) found = 1'b1;
          pa = clk_a;
        end
      join
      realign = !found;
      cycles(1);
      realign = 1'b0;
    end
    `CHK("loopback word", 1'b1, found)
  endtask
  task automatic t_ddr();
    logic lo, hit, pa;
    lo = 1'b0;
    hit = 1'b0;
    pa = 1'b1;
    width = 1'b1;
    cycles(40);
    on_grid();
    fork
      proto.send(W);
      repeat (60) begin
        @(negedge mclk_i);
        if (clk_a && !pa && rxw === {5'h00, W[4:0]}) lo = 1'b1;
        if (!clk_a && pa && lo && rxw === {5'h00, W[9:5]}) hit = 1'b1;
        pa = clk_a;
      end
    join
    `CHK("ddr groups", 1'b1, hit)
    width = 1'b0;
  endtask
  task automatic t_half();
    int   na, nb;
    logic pa, pb;
    na = 0;
    nb = 0;
    pa = 1'b1;
    pb = 1'b1;
    rate = 1'b0;
    cycles(40);
    on_grid();
    fork
      repeat (4) proto.send(W);
      repeat (90) begin
        @(negedge mclk_i);
        if (clk_a && !pa && rxw === W) na++;
        if (clk_b && !pb && rxw === W) nb++;
        pa = clk_a;
        pb = clk_b;
      end
    join
    `CHK("half clock split", 1'b1, (na == 0) != (nb == 0))
    `CHK("half words seen", 1'b1, na + nb >= 3)
    // slip in half rate, clocks must only stretch
    realign = 1'b1;
    cycles(1);
    realign = 1'b0;
    na = 0;
    nb = 0;
    repeat (60) begin
      @(negedge mclk_i);
      if (clk_a && !pa) na++;
      if (clk_b && !pb) nb++;
      pa = clk_a;
      pb = clk_b;
    end
    `CHK("half clocks after slip", 1'b1, na >= 2 && nb >= 2)
    `CHK("rx overflow", 1'b0, ovf)
  endtask
  initial begin
    repeat (3) @(negedge mclk_i);
    rst_b_i = 1'b1;
    cycles(10);
    t_tx(W);
    t_tx(10'h3c1);
    t_align();
    t_ddr();
    t_half();
    final_report();
  end
endmodule
